// [src/dhpb_bank.sv]
// Homing parameter bank: service channel registers and homing sequencer.
`timescale 1ns/1ps
`include "dhpb_map.svh"
module dhpb_bank (
    input wire logic clock,
    input wire logic reset,
    input wire dhpb_pkg::dhpb_svc_req_s svcReq,
    output dhpb_pkg::dhpb_svc_rsp_s svcRsp,
    input wire logic [2:0] commPhase,
    input wire dhpb_pkg::dhpb_mode_t savedSerialHoming,
    input wire logic backupWordValid,
    input wire logic [15:0] backupWord,
    input wire logic backupDone,
    input wire logic backupOk,
    input wire logic inputLevelOne,
    input wire logic inputLevelTwo,
    input wire logic inputLevelThree,
    input wire logic driveHomingCommand,
    input wire logic followingErrorHigh,
    input wire logic zeroMark,
    input wire logic homingFinished,
    output dhpb_pkg::dhpb_mode_t serialHomingSetting,
    output logic serialHomingStrobe,
    output dhpb_pkg::dhpb_mode_t homingModeUsed,
    output logic [15:0] homingControlWord,
    output logic [1:0] limitSwitchEnable,
    output logic homingActive,
    output logic torqueLimitEngage,
    output logic driveReverse,
    output logic homingFault
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    dhpb_pkg::dhpb_mode_t modeSel_reg;
    dhpb_pkg::dhpb_mode_t modeSel_next;
    dhpb_pkg::dhpb_mode_t modeUsed_reg;
    dhpb_pkg::dhpb_mode_t modeUsed_next;
    logic [15:0] cw_reg;
    logic [15:0] cw_next;
    logic [1:0] limit_reg;
    logic [1:0] limit_next;
    logic loadPending_reg;
    logic loadPending_next;
    dhpb_pkg::dhpb_svc_rsp_s rsp_reg;
    dhpb_pkg::dhpb_svc_rsp_s rsp_next;
    dhpb_pkg::dhpb_home_state_e state_reg;
    dhpb_pkg::dhpb_home_state_e state_next;
    dhpb_pkg::dhpb_mode_t serial_reg;
    dhpb_pkg::dhpb_mode_t serial_next;
    logic strobe_reg;
    logic strobe_next;
    logic fault_reg;
    logic fault_next;
    logic [15:0] checksum;
    logic [7:0] encWord;
    logic encKnown;
    logic phaseOk;
    logic selWrite;
    logic cwWrite;
    logic limWrite;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True while the communication phase allows parameter writes.
    function automatic logic writablePhase(input logic [2:0] phase);
        writablePhase = (phase >= `DHPB_CP_WRITE_MIN) && (phase <= `DHPB_CP_WRITE_MAX);
    endfunction

    // Recovers the homing mode from a control word, or keeps the current one.
    function automatic dhpb_pkg::dhpb_mode_t modeFromWord(input logic [7:0] w,
                                                          input dhpb_pkg::dhpb_mode_t keep);
        modeFromWord = keep;
        if ((w & `DHPB_MASK_WIDE) == `DHPB_CW_SET_REF) begin
            modeFromWord = 4'h0;
        end else if ((w & `DHPB_MASK_WIDE) == `DHPB_CW_NEXT_ZERO) begin
            modeFromWord = 4'h5;
        end else if ((w & `DHPB_MASK_NARROW) == `DHPB_CW_SWITCH) begin
            modeFromWord = 4'h1;
        end else if ((w & `DHPB_MASK_NARROW) == `DHPB_CW_NO_ZERO) begin
            modeFromWord = 4'h3;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sub-blocks.

    dhpb_checksum #(.WIDTH(16)) checksumUnit (
        .clock(clock),
        .reset(reset),
        .wordValid(backupWordValid),
        .word(backupWord),
        .backupDone(backupDone),
        .backupOk(backupOk),
        .checksum(checksum)
    );

    dhpb_mode_encode encoder (
        .mode(svcReq.data[3:0]),
        .oldWord(cw_reg[7:0]),
        .newWord(encWord),
        .known(encKnown)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Service channel decode.

    // Accepted writes; a selector write needs an in-range value.
    assign phaseOk = writablePhase(commPhase);
    assign selWrite = svcReq.valid && svcReq.write && phaseOk
                      && (svcReq.index == `DHPB_IDX_MODE_SEL)
                      && (svcReq.data <= 16'(`DHPB_MODE_MAX));
    assign cwWrite = svcReq.valid && svcReq.write && phaseOk
                     && (svcReq.index == `DHPB_IDX_HOMING_CW);
    assign limWrite = svcReq.valid && svcReq.write && phaseOk
                      && (commPhase != `DHPB_CP_LOCK)
                      && (svcReq.index == `DHPB_IDX_LIMIT_EN);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter registers.

    // Selector, mode in use, control word and limit-switch enables.
    always_comb begin
        modeSel_next = modeSel_reg;
        modeUsed_next = modeUsed_reg;
        cw_next = cw_reg;
        limit_next = limit_reg;
        loadPending_next = 1'b0;
        if (loadPending_reg) begin
            if (savedSerialHoming <= `DHPB_MODE_MAX) begin
                modeSel_next = savedSerialHoming;
                modeUsed_next = savedSerialHoming;
            end
        end else if (selWrite) begin
            modeSel_next = svcReq.data[3:0];
            modeUsed_next = svcReq.data[3:0];
            if (encKnown) begin
                cw_next = {cw_reg[15:8], encWord};
            end
        end else if (cwWrite) begin
            cw_next = svcReq.data;
            modeUsed_next = modeFromWord(svcReq.data[7:0], modeUsed_reg);
        end
        if (limWrite) begin
            limit_next = svcReq.data[1:0];
        end
    end

    // Answer to each read or write request, one cycle after the request.
    always_comb begin
        rsp_next = '0;
        if (svcReq.valid) begin
            rsp_next.ack = 1'b1;
            if (svcReq.write) begin
                rsp_next.error = !(selWrite || cwWrite || limWrite);
            end else begin
                case (svcReq.index)
                    `DHPB_IDX_CHECKSUM: rsp_next.data = checksum;
                    `DHPB_IDX_MODE_SEL: rsp_next.data = {12'h000, modeSel_reg};
                    `DHPB_IDX_IN_ONE: rsp_next.data = {15'h0000, inputLevelOne};
                    `DHPB_IDX_IN_TWO: rsp_next.data = {15'h0000, inputLevelTwo};
                    `DHPB_IDX_IN_THREE: rsp_next.data = {15'h0000, inputLevelThree};
                    `DHPB_IDX_HOMING_CW: rsp_next.data = cw_reg;
                    `DHPB_IDX_LIMIT_EN: rsp_next.data = {14'h0000, limit_reg};
                    default: rsp_next.error = 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Homing sequencer.

    // Starts a homing run with the mode in use and follows its phases.
    always_comb begin
        state_next = state_reg;
        serial_next = serial_reg;
        strobe_next = 1'b0;
        fault_next = fault_reg;
        case (state_reg)
            dhpb_pkg::HOME_IDLE: begin
                if (driveHomingCommand) begin
                    serial_next = modeUsed_reg;
                    strobe_next = 1'b1;
                    fault_next = 1'b0;
                    if (modeUsed_reg == `DHPB_MODE_STOP) begin
                        state_next = dhpb_pkg::HOME_SEEK;
                    end else if (modeUsed_reg == `DHPB_MODE_LIMIT && limit_reg == 2'h0) begin
                        fault_next = 1'b1; // No stop input enabled
                    end else begin
                        state_next = dhpb_pkg::HOME_RUN;
                    end
                end
            end
            dhpb_pkg::HOME_RUN: begin
                if (homingFinished) begin
                    state_next = dhpb_pkg::HOME_IDLE;
                end
            end
            dhpb_pkg::HOME_SEEK: begin
                if (followingErrorHigh) begin
                    state_next = dhpb_pkg::HOME_REVERSE; // Blocked at the stop
                end
            end
            dhpb_pkg::HOME_REVERSE: begin
                if (zeroMark) begin
                    state_next = dhpb_pkg::HOME_IDLE;
                end
            end
            default: begin
                state_next = dhpb_pkg::HOME_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers.

    // Reset values; the selector is refilled from the saved setting next, if that setting is in range.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            modeSel_reg <= `DHPB_MODE_RESET;
            modeUsed_reg <= `DHPB_MODE_RESET;
            cw_reg <= `DHPB_CW_RESET;
            limit_reg <= `DHPB_LIMIT_RESET;
            loadPending_reg <= 1'b1;
            rsp_reg <= '0;
            state_reg <= dhpb_pkg::HOME_IDLE;
            serial_reg <= `DHPB_MODE_RESET;
            strobe_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            modeSel_reg <= modeSel_next;
            modeUsed_reg <= modeUsed_next;
            cw_reg <= cw_next;
            limit_reg <= limit_next;
            loadPending_reg <= loadPending_next;
            rsp_reg <= rsp_next;
            state_reg <= state_next;
            serial_reg <= serial_next;
            strobe_reg <= strobe_next;
            fault_reg <= fault_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign svcRsp = rsp_reg;
    assign serialHomingSetting = serial_reg;
    assign serialHomingStrobe = strobe_reg;
    assign homingModeUsed = modeUsed_reg;
    assign homingControlWord = cw_reg;
    assign limitSwitchEnable = limit_reg;
    assign homingActive = (state_reg != dhpb_pkg::HOME_IDLE);
    assign torqueLimitEngage = (state_reg == dhpb_pkg::HOME_SEEK)
                               || (state_reg == dhpb_pkg::HOME_REVERSE);
    assign driveReverse = (state_reg == dhpb_pkg::HOME_REVERSE);
    assign homingFault = fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_sel_write_ok;
        svcReq.valid && svcReq.write && svcReq.index == `DHPB_IDX_MODE_SEL
        && writablePhase(commPhase) && svcReq.data <= 16'h0007 && !loadPending_reg;
    endsequence

    sequence s_stop_start;
        state_reg == dhpb_pkg::HOME_IDLE && driveHomingCommand && modeUsed_reg == 4'h7;
    endsequence

    property p_sel_range;
        @(posedge clock) disable iff (reset) modeSel_reg <= 4'h7;
    endproperty
    a_sel_range: assert property (p_sel_range)
        else $error("selector left its range");

    property p_sel_reject;
        @(posedge clock) disable iff (reset)
        svcReq.valid && svcReq.write && svcReq.index == `DHPB_IDX_MODE_SEL
        && svcReq.data > 16'h0007 && !loadPending_reg
        |=> $stable(modeSel_reg) && svcRsp.ack && svcRsp.error;
    endproperty
    a_sel_reject: assert property (p_sel_reject)
        else $error("out-of-range selector write not rejected");

    property p_reset_load;
        @(posedge clock) disable iff (reset)
        loadPending_reg && savedSerialHoming <= 4'h7 |=> modeSel_reg == $past(savedSerialHoming);
    endproperty
    a_reset_load: assert property (p_reset_load)
        else $error("selector not loaded from saved setting");

    property p_write_mode;
        @(posedge clock) disable iff (reset)
        s_sel_write_ok |=> homingModeUsed == $past(svcReq.data[3:0]) && svcRsp.ack && !svcRsp.error;
    endproperty
    a_write_mode: assert property (p_write_mode)
        else $error("selector write did not set mode in use");

    property p_serial_copy;
        @(posedge clock) disable iff (reset)
        state_reg == dhpb_pkg::HOME_IDLE && driveHomingCommand
        |=> serialHomingStrobe && serialHomingSetting == $past(modeUsed_reg);
    endproperty
    a_serial_copy: assert property (p_serial_copy)
        else $error("homing did not copy mode to serial setting");

    property p_cw_default;
        @(posedge clock) disable iff (reset)
        loadPending_reg |-> cw_reg == 16'h0084 && modeSel_reg == 4'h1;
    endproperty
    a_cw_default: assert property (p_cw_default)
        else $error("reset defaults wrong");

    property p_stop_seek;
        @(posedge clock) disable iff (reset)
        s_stop_start |=> torqueLimitEngage && !driveReverse
        ##[0:1000] (followingErrorHigh || !homingActive);
    endproperty
    a_stop_seek: assert property (p_stop_seek)
        else $error("mechanical stop seek wrong");

    property p_stop_reverse;
        @(posedge clock) disable iff (reset)
        state_reg == dhpb_pkg::HOME_SEEK && followingErrorHigh |=> driveReverse;
    endproperty
    a_stop_reverse: assert property (p_stop_reverse)
        else $error("no reversal after blocked motion");

    property p_limit_lock;
        @(posedge clock) disable iff (reset)
        svcReq.valid && svcReq.write && svcReq.index == `DHPB_IDX_LIMIT_EN && commPhase == 3'h4
        |=> $stable(limitSwitchEnable) && svcRsp.error;
    endproperty
    a_limit_lock: assert property (p_limit_lock)
        else $error("limit enable changed in phase 4");

    property p_mode1_word;
        @(posedge clock) disable iff (reset)
        s_sel_write_ok and (svcReq.data[3:0] == 4'h1) |=> cw_reg[7:1] == 7'h42;
    endproperty
    a_mode1_word: assert property (p_mode1_word)
        else $error("mode 1 control word pattern wrong");

    property p_input_read;
        @(posedge clock) disable iff (reset)
        svcReq.valid && !svcReq.write && svcReq.index == `DHPB_IDX_IN_ONE
        |=> svcRsp.data == {15'h0000, $past(inputLevelOne)} && !svcRsp.error;
    endproperty
    a_input_read: assert property (p_input_read)
        else $error("input status read wrong");

endmodule

// [src/dhpb_checksum.sv]
// Running checksum of backed-up words, published only on a good backup.
`timescale 1ns/1ps
module dhpb_checksum #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic wordValid,
    input wire logic [WIDTH-1:0] word,
    input wire logic backupDone,
    input wire logic backupOk,
    output logic [WIDTH-1:0] checksum
);

    logic [WIDTH-1:0] sum_reg;
    logic [WIDTH-1:0] sum_next;
    logic [WIDTH-1:0] checksum_reg;
    logic [WIDTH-1:0] checksum_next;

    // Accumulate during the backup; publish only a successful result.
    always_comb begin
        sum_next = sum_reg;
        checksum_next = checksum_reg;
        if (backupDone) begin
            sum_next = '0;
            if (backupOk) begin
                checksum_next = sum_reg;
            end
        end else if (wordValid) begin
            sum_next = sum_reg + word;
        end
    end

    // State registers.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sum_reg <= '0;
            checksum_reg <= '0;
        end else begin
            sum_reg <= sum_next;
            checksum_reg <= checksum_next;
        end
    end

    assign checksum = checksum_reg;

    // The published value moves only on a successful backup.
    property p_checksum_hold;
        @(posedge clock) disable iff (reset)
        !(backupDone && backupOk) |=> $stable(checksum_reg);
    endproperty
    a_checksum_hold: assert property (p_checksum_hold)
        else $error("checksum changed without a good backup");

endmodule

// [src/dhpb_map.svh]
// Offsets, field values, reset values and encodings of the homing parameter bank.
`ifndef DHPB_MAP_SVH
`define DHPB_MAP_SVH

`define DHPB_IDX_CHECKSUM 16'h8BD2
`define DHPB_IDX_MODE_SEL 16'h8BD3
`define DHPB_IDX_IN_ONE 16'h8BD6
`define DHPB_IDX_IN_TWO 16'h8BD7
`define DHPB_IDX_IN_THREE 16'h8BD8
`define DHPB_IDX_HOMING_CW 16'h0093
`define DHPB_IDX_LIMIT_EN 16'h8BF0

`define DHPB_MODE_RESET 4'h1
`define DHPB_MODE_MAX 4'h7
`define DHPB_MODE_LIMIT 4'h2
`define DHPB_MODE_STOP 4'h7
`define DHPB_CW_RESET 16'h0084
`define DHPB_LIMIT_RESET 2'h0
`define DHPB_CP_WRITE_MIN 3'h2
`define DHPB_CP_WRITE_MAX 3'h4
`define DHPB_CP_LOCK 3'h4

`define DHPB_CW_SET_REF 8'hE0
`define DHPB_CW_SWITCH 8'h84
`define DHPB_CW_NO_ZERO 8'hC4
`define DHPB_CW_NEXT_ZERO 8'hA0
`define DHPB_MASK_WIDE 8'hF8
`define DHPB_MASK_NARROW 8'hFE

`endif

// [src/dhpb_mode_encode.sv]
// Maps a homing mode onto bits 7-0 of the homing control word.
`timescale 1ns/1ps
`include "dhpb_map.svh"
module dhpb_mode_encode (
    input wire dhpb_pkg::dhpb_mode_t mode,
    input wire logic [7:0] oldWord,
    output logic [7:0] newWord,
    output logic known
);

    // Fixed pattern bits are forced, the free low bits keep the old word.
    always_comb begin
        newWord = oldWord;
        known = 1'b1;
        case (mode)
            4'h0, 4'h6: begin
                newWord = (oldWord & ~`DHPB_MASK_WIDE) | `DHPB_CW_SET_REF;
            end
            4'h1, 4'h2, 4'h7: begin
                newWord = (oldWord & ~`DHPB_MASK_NARROW) | `DHPB_CW_SWITCH;
            end
            4'h3, 4'h4: begin
                newWord = (oldWord & ~`DHPB_MASK_NARROW) | `DHPB_CW_NO_ZERO;
            end
            4'h5: begin
                newWord = (oldWord & ~`DHPB_MASK_WIDE) | `DHPB_CW_NEXT_ZERO;
            end
            default: begin
                known = 1'b0; // Modes 8 to 15 carry no pattern
            end
        endcase
    end

endmodule

// [src/dhpb_pkg.sv]
// Types shared by the homing parameter bank modules.
package dhpb_pkg;

    typedef logic [3:0] dhpb_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [15:0] data;
    } dhpb_svc_req_s;

    typedef struct packed {
        logic ack;
        logic error;
        logic [15:0] data;
    } dhpb_svc_rsp_s;

    typedef enum {HOME_IDLE, HOME_RUN, HOME_SEEK, HOME_REVERSE} dhpb_home_state_e;

endpackage

// [test/dhpb_master_model.sv]
// Motion master model that issues service-channel requests to the parameter bank.
`timescale 1ns/1ps
module dhpb_master_model (
    input wire logic clock,
    input wire dhpb_pkg::dhpb_svc_rsp_s svcRsp,
    output dhpb_pkg::dhpb_svc_req_s svcReq
);
    ////////////////////////////////////////////////////////////////////////////////
    // The channel is idle until the first request.
    initial begin
        svcReq = '0;
    end

    // Sends one request for one cycle and collects the answer.
    // A missing answer comes back with ack low, so the caller notices it.
    task automatic access(input logic write, input logic [15:0] index,
                          input logic [15:0] data, output dhpb_pkg::dhpb_svc_rsp_s rsp);
        int n;
        rsp = '0;
        @(negedge clock);
        svcReq = '{valid: 1'b1, write: write, index: index, data: data};
        @(negedge clock);
        // Released lines carry the inverse, so a stale request cannot pass for a live one.
        svcReq = '{valid: 1'b0, write: ~write, index: ~index, data: ~data};
        for (n = 0; n < 3 && rsp.ack !== 1'b1; n++) begin
            if (svcRsp.ack === 1'b1) begin
                rsp = svcRsp;
            end else begin
                @(negedge clock);
            end
        end
    endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the homing parameter bank.
`timescale 1ns/1ps
`include "dhpb_map.svh"
module testbench;
    logic clock, reset, backupWordValid, backupDone, backupOk;
    logic inputLevelOne, inputLevelTwo, inputLevelThree, driveHomingCommand;
    logic followingErrorHigh, zeroMark, homingFinished, serialHomingStrobe;
    logic homingActive, torqueLimitEngage, driveReverse, homingFault;
    logic [2:0] commPhase;
    logic [15:0] backupWord, homingControlWord;
    logic [1:0] limitSwitchEnable;
    dhpb_pkg::dhpb_svc_req_s svcReq;
    dhpb_pkg::dhpb_svc_rsp_s svcRsp, rsp;
    dhpb_pkg::dhpb_mode_t savedSerialHoming, serialHomingSetting, homingModeUsed;
    int mismatches, totalChecks;
    logic [15:0] cwPattern [8] = '{16'h00E0, 16'h0084, 16'h0084, 16'h00C4,
        16'h00C4, 16'h00A0, 16'h00E0, 16'h0084};
    logic [15:0] cwMask [8] = '{16'h00F8, 16'h00FE, 16'h00FE, 16'h00FE,
        16'h00FE, 16'h00F8, 16'h00F8, 16'h00FE};

    dhpb_bank dut (.clock, .reset, .svcReq, .svcRsp, .commPhase, .savedSerialHoming,
        .backupWordValid, .backupWord, .backupDone, .backupOk, .inputLevelOne,
        .inputLevelTwo, .inputLevelThree, .driveHomingCommand, .followingErrorHigh,
        .zeroMark, .homingFinished, .serialHomingSetting, .serialHomingStrobe,
        .homingModeUsed, .homingControlWord, .limitSwitchEnable, .homingActive,
        .torqueLimitEngage, .driveReverse, .homingFault);
    dhpb_master_model master (.clock(clock), .svcRsp(svcRsp), .svcReq(svcReq));

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 20 MHz clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Compares one word and counts the result.
    task automatic check_word(input logic [15:0] actual, input logic [15:0] expected);
        totalChecks++;
        if (actual !== expected) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, actual, expected);
        end
    endtask

    // Writes a parameter and checks that the answer comes with the expected error flag.
    task automatic write_reg(input logic [15:0] index, input logic [15:0] data, input logic err);
        master.access(1'b1, index, data, rsp);
        check_word({14'h0000, rsp.ack, rsp.error}, {14'h0000, 1'b1, err});
    endtask

    // Reads a parameter and checks flags and data.
    task automatic read_reg(input logic [15:0] index, input logic [15:0] data, input logic err);
        master.access(1'b0, index, 16'h0000, rsp);
        check_word({14'h0000, rsp.ack, rsp.error}, {14'h0000, 1'b1, err});
        check_word(rsp.data, data);
    endtask

    // Raises the homing command for one cycle.
    task automatic start_homing(input logic [15:0] mode);
        write_reg(`DHPB_IDX_MODE_SEL, mode, 1'b0);
        @(negedge clock);
        driveHomingCommand = 1'b1;
        @(negedge clock);
        driveHomingCommand = 1'b0;
    endtask

    // Streams two words into the backup and ends it with the given outcome.
    task automatic backup(input logic [15:0] a, input logic [15:0] b, input logic ok);
        @(negedge clock);
        backupWordValid = 1'b1;
        backupWord = a;
        @(negedge clock);
        backupWord = b;
        @(negedge clock);
        backupWordValid = 1'b0;
        backupDone = 1'b1;
        backupOk = ok;
        @(negedge clock);
        backupDone = 1'b0;
        backupOk = ~ok;
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The tests need well under 1000 cycles, so 20000 means a hang.
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end

    // Main sequence of tests.
    initial begin
        {reset, commPhase, savedSerialHoming} = {1'b1, 3'h3, 4'h5};
        {backupWordValid, backupWord, backupDone, backupOk} = '0;
        {inputLevelOne, inputLevelTwo, inputLevelThree, driveHomingCommand} = '0;
        {followingErrorHigh, zeroMark, homingFinished} = '0;
        mismatches = 0;
        totalChecks = 0;
        repeat (6) @(negedge clock);
        check_word(homingControlWord, 16'h0084);
        check_word({12'h000, homingModeUsed}, 16'h0001);
        reset = 1'b0;
        repeat (2) @(negedge clock);
        read_reg(`DHPB_IDX_MODE_SEL, 16'h0005, 1'b0);
        // Each input word shows its own level in bit 0 only.
        for (int i = 0; i < 2; i++) begin
            {inputLevelOne, inputLevelTwo, inputLevelThree} = {i[0], ~i[0], i[0]};
            read_reg(`DHPB_IDX_IN_ONE, {15'h0000, i[0]}, 1'b0);
            read_reg(`DHPB_IDX_IN_TWO, {15'h0000, ~i[0]}, 1'b0);
            read_reg(`DHPB_IDX_IN_THREE, {15'h0000, i[0]}, 1'b0);
        end
        write_reg(`DHPB_IDX_IN_TWO, 16'hFFFF, 1'b1);
        write_reg(`DHPB_IDX_CHECKSUM, 16'h1111, 1'b1);
        // Every selector value reaches the mode and the control word pattern.
        for (int m = 0; m < 8; m++) begin
            write_reg(`DHPB_IDX_MODE_SEL, 16'(m), 1'b0);
            read_reg(`DHPB_IDX_MODE_SEL, 16'(m), 1'b0);
            check_word({12'h000, homingModeUsed}, 16'(m));
            check_word(homingControlWord & cwMask[m], cwPattern[m]);
        end
        write_reg(`DHPB_IDX_MODE_SEL, 16'h0008, 1'b1);
        read_reg(`DHPB_IDX_MODE_SEL, 16'h0007, 1'b0);
        commPhase = 3'h1;
        write_reg(`DHPB_IDX_MODE_SEL, 16'h0003, 1'b1);
        read_reg(`DHPB_IDX_MODE_SEL, 16'h0007, 1'b0);
        commPhase = 3'h4;
        write_reg(`DHPB_IDX_MODE_SEL, 16'h0001, 1'b0);
        write_reg(`DHPB_IDX_HOMING_CW, 16'h00A0, 1'b0);
        check_word({12'h000, homingModeUsed}, 16'h0005);
        read_reg(`DHPB_IDX_HOMING_CW, 16'h00A0, 1'b0);
        write_reg(`DHPB_IDX_LIMIT_EN, 16'h0001, 1'b1);
        check_word({14'h0000, limitSwitchEnable}, 16'h0000);
        commPhase = 3'h3;
        // Mode 2 with no stop input enabled is refused with a fault.
        start_homing(16'h0002);
        check_word({14'h0000, homingFault, homingActive}, 16'h0002);
        write_reg(`DHPB_IDX_LIMIT_EN, 16'h0001, 1'b0);
        check_word({14'h0000, limitSwitchEnable}, 16'h0001);
        start_homing(16'h0002);
        check_word({11'h000, serialHomingStrobe, serialHomingSetting}, 16'h0012);
        check_word({14'h0000, homingFault, homingActive}, 16'h0001);
        homingFinished = 1'b1;
        @(negedge clock);
        homingFinished = 1'b0;
        check_word({15'h0000, homingActive}, 16'h0000);
        // Mode 7 seeks the stop under torque limit, then reverses to the zero mark.
        start_homing(16'h0007);
        check_word({12'h000, torqueLimitEngage, driveReverse, homingActive, 1'b0}, 16'h000A);
        followingErrorHigh = 1'b1;
        @(negedge clock);
        followingErrorHigh = 1'b0;
        check_word({12'h000, torqueLimitEngage, driveReverse, homingActive, 1'b0}, 16'h000E);
        zeroMark = 1'b1;
        @(negedge clock);
        zeroMark = 1'b0;
        check_word({12'h000, torqueLimitEngage, driveReverse, homingActive, 1'b0}, 16'h0000);
        backup(16'h1234, 16'h0F0F, 1'b1);
        read_reg(`DHPB_IDX_CHECKSUM, 16'h2143, 1'b0);
        backup(16'h0001, 16'h0002, 1'b0);
        read_reg(`DHPB_IDX_CHECKSUM, 16'h2143, 1'b0);
        read_reg(16'h8BD4, 16'h0000, 1'b1);
        // A second reset with an out-of-range saved setting keeps the default mode.
        savedSerialHoming = 4'h9;
        reset = 1'b1;
        @(negedge clock);
        reset = 1'b0;
        repeat (2) @(negedge clock);
        read_reg(`DHPB_IDX_MODE_SEL, 16'h0001, 1'b0);
        read_reg(`DHPB_IDX_CHECKSUM, 16'h0000, 1'b0);
        end_of_test();
    end
endmodule
